// ### logic/sgls_top.sv
// Purpose: two output pins driven locally or remotely, plus link status
// Assumes: remote levels, crc error and link detect arrive asynchronously
// Notes: direction is fixed as output; pins are never inputs here
//        link and crc events are ignored until the synchronisers fill
//        addresses beyond the register window answer with an error
//        the crc reset control must be written back to zero by software
`timescale 1ns/100ps
module sgls_top
   import sgls_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [SGLS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [SGLS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // link side status inputs
   input wire logic link_detect,
   input wire logic back_crc_error,
   input wire logic remote_pin_zero,
   input wire logic remote_pin_one,
   // output pins
   output logic output_pin_zero,
   output logic output_pin_zero_oe,
   output logic output_pin_one,
   output logic output_pin_one_oe,
   // interrupt
   output logic irq
);

   // synchronised link side inputs, oldest sample in bit 1
   logic [3:0] sync_in;
   logic [1:0] sync_q [4];
   logic [1:0] link_s;
   logic [1:0] crc_s;
   logic [1:0] rz_s;
   logic [1:0] ro_s;
   logic [1:0] warm;

   // edge detect, register storage and bus holding state
   logic crc_prev;
   logic link_prev;
   logic des_error;
   logic [7:0] pincfg;
   logic [7:0] ctrl;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic aw_held;
   logic w_held;
   logic [SGLS_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;

   // decode and event helpers
   logic crc_evt;
   logic link_evt;
   logic crc_clr;
   logic [31:0] next_rdata;
   logic next_rhit;

   // per bit and per pin slices
   logic [1:0] irq_evt;
   logic [1:0] irq_clr;
   logic [1:0] remote_s;
   logic [1:0] pin_lvl;
   logic [1:0] pin_oe;
   localparam int PIN_STRIDE = SGLS_P1_ACTIVE - SGLS_P0_ACTIVE;

   // two-flop synchronisers for everything from the link side
   // bit order: link, crc, remote zero, remote one
   assign sync_in = {remote_pin_one, remote_pin_zero, back_crc_error,
                     link_detect};
   generate
      for (genvar b = 0; b < 4; b++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync_q[b] <= 2'h0;
            end else begin
               sync_q[b] <= {sync_q[b][0], sync_in[b]};
            end
         end
      end
   endgenerate

   assign link_s = sync_q[0];
   assign crc_s = sync_q[1];
   assign rz_s = sync_q[2];
   assign ro_s = sync_q[3];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crc_prev <= 1'b0;
         link_prev <= 1'b0;
      end else begin
         crc_prev <= crc_s[1];
         link_prev <= link_s[1];
      end
   end

   // reset fills the synchronisers with zeros; a link already up would
   // otherwise show as a change two edges after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         warm <= 2'h0;
      end else if (warm != 2'h3) begin
         warm <= warm + 2'h1;
      end
   end

   assign crc_evt = crc_s[1] & ~crc_prev & (warm == 2'h3);
   assign link_evt = (link_s[1] ^ link_prev) & (warm == 2'h3);
   // crc reset control acts as a level while held high by software
   assign crc_clr = ctrl[SGLS_CRC_RST_BIT] | ~link_s[1];

   // set wins over clear so a coincident error is not lost
   // link loss clears the flag as a level, like the reset control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         des_error <= 1'b0;
      end else if (crc_evt) begin
         des_error <= 1'b1;
      end else if (crc_clr) begin
         des_error <= 1'b0;
      end
   end

   // axi write channel: address and data taken in either order
   // awready and wready pulse for one cycle and rest for one, so a
   // request waits at most two edges; nothing new is taken while a
   // write sits in the holding registers; one taken while the last response is unread waits there
   assign wr_go = aw_held & w_held & ~s_axi_bvalid;
   // an address above the index range maps to an unused index
   assign wr_idx = (|aw_addr[SGLS_ADDR_W-1:10]) ? 8'hFF : aw_addr[9:2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_held & ~s_axi_awready;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= ~w_held & ~s_axi_wready;
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end

   // the response waits for both halves and is held until bready
   // status is read-only: a write there is answered but changes nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= SGLS_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         case (wr_idx)
            SGLS_IDX_PINCFG, SGLS_IDX_CTRL, SGLS_IDX_STATUS,
            SGLS_IDX_IRQ_STAT, SGLS_IDX_IRQ_MASK:
               s_axi_bresp <= SGLS_RESP_OKAY;
            default: s_axi_bresp <= SGLS_RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // reserved bits are plain storage, never read by the pin logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pincfg <= SGLS_PINCFG_RST;
      end else if (wr_go && wr_idx == SGLS_IDX_PINCFG && w_strb[0]) begin
         pincfg <= w_data[7:0];
      end
   end

   // crc reset bit is a level: software writes it back to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= SGLS_CTRL_RST;
      end else if (wr_go && wr_idx == SGLS_IDX_CTRL && w_strb[0]) begin
         ctrl <= w_data[7:0];
      end
   end

   // mask only gates status bits onto irq, it holds no event itself
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask <= SGLS_IRQ_RST;
      end else if (wr_go && wr_idx == SGLS_IDX_IRQ_MASK && w_strb[0]) begin
         irq_mask <= w_data[1:0];
      end
   end

   // write one to clear; a new event in the same cycle keeps its bit
   assign irq_evt = {crc_evt, link_evt};
   assign irq_clr = (wr_go && wr_idx == SGLS_IDX_IRQ_STAT && w_strb[0]) ?
                    w_data[1:0] : 2'h0;
   generate
      for (genvar i = 0; i < 2; i++) begin : g_irq
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               irq_stat[i] <= SGLS_IRQ_RST[i];
            end else if (irq_evt[i]) begin
               irq_stat[i] <= 1'b1;
            end else if (irq_clr[i]) begin
               irq_stat[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // irq is registered so the pin never glitches on a decode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   // read channel, same alias guard as the write side
   assign rd_idx = (|s_axi_araddr[SGLS_ADDR_W-1:10]) ? 8'hFF :
                   s_axi_araddr[9:2];

   // unmapped indices read zero and flag an error
   always_comb begin
      next_rdata = 32'h00000000;
      next_rhit = 1'b1;
      case (rd_idx)
         SGLS_IDX_STATUS: begin
            next_rdata[SGLS_DES_ERR_BIT] = des_error;
            next_rdata[SGLS_LINK_BIT] = link_s[1];
         end
         SGLS_IDX_PINCFG: next_rdata[7:0] = pincfg;
         SGLS_IDX_CTRL: next_rdata[7:0] = ctrl;
         SGLS_IDX_IRQ_STAT: next_rdata[1:0] = irq_stat;
         SGLS_IDX_IRQ_MASK: next_rdata[1:0] = irq_mask;
         default: next_rhit = 1'b0;
      endcase
   end

   // read data are captured at the address edge and stand with rvalid
   // until rready; arready stays low meanwhile, so one read at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= SGLS_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rhit ? SGLS_RESP_OKAY : SGLS_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // pin drive, one slice per pin; remote level only when remote bit set
   // direction bits are not modelled, so an enabled pin always drives
   // oe and level are both registered so the pins change together
   assign remote_s = {ro_s[1], rz_s[1]};
   generate
      for (genvar p = 0; p < 2; p++) begin : g_pin
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               pin_lvl[p] <= 1'b0;
               pin_oe[p] <= 1'b0;
            end else begin
               pin_oe[p] <= pincfg[p*PIN_STRIDE+SGLS_P0_ACTIVE];
               if (pincfg[p*PIN_STRIDE+SGLS_P0_REMOTE]) begin
                  pin_lvl[p] <= remote_s[p];
               end else begin
                  pin_lvl[p] <= pincfg[p*PIN_STRIDE+SGLS_P0_LEVEL];
               end
            end
         end
      end
   endgenerate

   // pins leave straight from the slice flops
   assign output_pin_zero = pin_lvl[0];
   assign output_pin_zero_oe = pin_oe[0];
   assign output_pin_one = pin_lvl[1];
   assign output_pin_one_oe = pin_oe[1];

endmodule

// ### logic/sgls_pkg.sv
// Purpose: shared constants for the output pin pair and link status block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: byte offsets are register indices times four
package sgls_pkg;
   // register indices as printed, byte address is index times four
   localparam logic [7:0] SGLS_IDX_STATUS = 8'h0C;
   localparam logic [7:0] SGLS_IDX_PINCFG = 8'h0D;
   localparam logic [7:0] SGLS_IDX_CTRL = 8'h03;
   localparam logic [7:0] SGLS_IDX_IRQ_STAT = 8'h20;
   localparam logic [7:0] SGLS_IDX_IRQ_MASK = 8'h21;
   localparam int SGLS_ADDR_W = 12;
   // general status fields
   localparam int SGLS_LINK_BIT = 0;
   localparam int SGLS_DES_ERR_BIT = 1;
   // control register field
   localparam int SGLS_CRC_RST_BIT = 5;
   // pin configuration fields
   localparam int SGLS_P0_ACTIVE = 0;
   localparam int SGLS_P0_REMOTE = 2;
   localparam int SGLS_P0_LEVEL = 3;
   localparam int SGLS_P1_ACTIVE = 4;
   localparam int SGLS_P1_REMOTE = 6;
   localparam int SGLS_P1_LEVEL = 7;
   localparam logic [7:0] SGLS_PINCFG_RST = 8'h55;
   localparam logic [7:0] SGLS_CTRL_RST = 8'h00;
   // interrupt fields: bit0 link change, bit1 crc error
   localparam int SGLS_IRQ_LINK = 0;
   localparam int SGLS_IRQ_CRC = 1;
   localparam logic [1:0] SGLS_IRQ_RST = 2'h0;
   localparam logic [1:0] SGLS_RESP_OKAY = 2'h0;
   localparam logic [1:0] SGLS_RESP_SLVERR = 2'h2;
endpackage

// ### verif/sgls_asserts.sv
// Purpose: port checks for the pin pair and link status block
// Assumes: write address and data are taken at the same edge
// Notes: shadows follow pin config and irq mask from bus writes
`timescale 1ns/100ps
module sgls_asserts
   import sgls_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus
   input wire logic [SGLS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [SGLS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   // link and pins
   input wire logic link_detect,
   input wire logic back_crc_error,
   input wire logic remote_pin_zero,
   input wire logic remote_pin_one,
   input wire logic output_pin_zero,
   input wire logic output_pin_zero_oe,
   input wire logic output_pin_one,
   input wire logic output_pin_one_oe,
   input wire logic irq
);
   localparam logic [11:0] A_ST = {2'h0, SGLS_IDX_STATUS, 2'h0};
   localparam logic [11:0] A_CFG = {2'h0, SGLS_IDX_PINCFG, 2'h0};
   localparam logic [11:0] A_MSK = {2'h0, SGLS_IDX_IRQ_MASK, 2'h0};
   logic [7:0] cfg;
   logic [1:0] mask;
   logic [11:0] ra;
   logic [3:0] calm;
   logic wr;
   assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready && s_axi_wstrb[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= SGLS_PINCFG_RST;
         mask <= 2'h0;
      end else if (wr && s_axi_awaddr == A_CFG) begin
         cfg <= s_axi_wdata[7:0];
      end else if (wr && s_axi_awaddr == A_MSK) begin
         mask <= s_axi_wdata[1:0];
      end
   end
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         ra <= s_axi_araddr;
      end
   end
   // settle count: sync flops need a few edges after reset or a change
   always_ff @(posedge aclk) begin
      if (!aresetn || $changed(link_detect) || $changed(back_crc_error)) begin
         calm <= 4'h0;
      end else if (calm != 4'hF) begin
         calm <= calm + 4'h1;
      end
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_crc_irq: assert property (
      $rose(back_crc_error) && mask[1] |-> ##[1:6] irq)
      else $error("crc event left irq low");
   a_flag_clear: assert property (
      $rose(s_axi_rvalid) && ra == A_ST && calm > 4'h6 && !link_detect
      |-> !s_axi_rdata[1]) else $error("error flag kept without link");
   a_link_flag: assert property (
      $rose(s_axi_rvalid) && ra == A_ST && calm > 4'h6
      |-> s_axi_rdata[0] == link_detect) else $error("link flag wrong");
   a_local_lvl: assert property (
      $stable(cfg)[*3] ##0 (calm > 4'h6 && cfg[0] && !cfg[2])
      |-> output_pin_zero == cfg[3]) else $error("local level wrong");
   a_remote_lvl: assert property (
      $stable({cfg, remote_pin_zero})[*4] ##0 (calm > 4'h6 && cfg[2])
      |-> output_pin_zero == remote_pin_zero) else $error("remote level");
   a_remote_ign: assert property (
      $stable(cfg)[*3] ##0 (calm > 4'h6 && !cfg[6] && $changed(remote_pin_one))
      |=> $stable(output_pin_one)[*4]) else $error("remote not ignored");
   a_pin_enable: assert property (
      $stable(cfg)[*3] ##0 calm > 4'h6 |-> output_pin_zero_oe == cfg[0]
      && output_pin_one_oe == cfg[4]) else $error("pin enable wrong");
   a_rsvd_keep: assert property (
      $rose(s_axi_rvalid) && ra == A_CFG |-> s_axi_rdata == {24'h0, cfg})
      else $error("pin config readback wrong");
endmodule
bind sgls_top sgls_asserts chk_u (.*);

// ### verif/sgls_remote.sv
// Purpose: remote end model for link detect, crc events and pin levels
// Assumes: commands come from the bench just after aclk edges
// Notes: a crc event lasts as long as the bench holds crc_req
`timescale 1ns/100ps
module sgls_remote (
   // clock and commands
   input wire logic aclk,
   input wire logic [1:0] want_pins,
   input wire logic want_link,
   input wire logic crc_req,
   // link side
   output logic remote_pin_zero,
   output logic remote_pin_one,
   output logic link_detect,
   output logic back_crc_error
);
   always @(posedge aclk) begin
      {remote_pin_one, remote_pin_zero} <= want_pins;
      link_detect <= want_link;
      back_crc_error <= crc_req;
   end
endmodule

// ### verif/tb_serializer_gpo_and_link_status.sv
// Purpose: self-checking bench for the pin pair and link status block
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes: expectations come from the register layout alone
`timescale 1ns/100ps
module tb_serializer_gpo_and_link_status;
   import sgls_pkg::*;
   localparam logic [11:0] A_ST = {2'h0, SGLS_IDX_STATUS, 2'h0};
   localparam logic [11:0] A_CFG = {2'h0, SGLS_IDX_PINCFG, 2'h0};
   localparam logic [11:0] A_CTL = {2'h0, SGLS_IDX_CTRL, 2'h0};
   localparam logic [11:0] A_IST = {2'h0, SGLS_IDX_IRQ_STAT, 2'h0};
   localparam logic [11:0] A_MSK = {2'h0, SGLS_IDX_IRQ_MASK, 2'h0};
   localparam logic [1:0] OK = SGLS_RESP_OKAY;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, want_pins;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, want_link, crc_req, irq;
   logic link_detect, back_crc_error, remote_pin_zero, remote_pin_one;
   logic output_pin_zero, output_pin_zero_oe;
   logic output_pin_one, output_pin_one_oe;
   int n_fail = 0, checks = 0, cyc = 0;
   sgls_top dut_u (.*);
   sgls_remote far_u (.*);
   always #50 aclk = ~aclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic da, dw;
      da = 1'b0;
      dw = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(da && dw)) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         da = da | s_axi_awready;
         dw = dw | s_axi_wready;
      end
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b0;
      check(32'(s_axi_bresp), (a == 12'h100) ? 32'h2 : 32'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata & m, ed);
      check(32'(s_axi_rresp), 32'(er));
   endtask
   task automatic settle(input logic lk, input logic cr);
      want_link <= lk;
      crc_req <= cr;
      repeat (2) @(posedge aclk);
      crc_req <= 1'b0;
      repeat (8) @(posedge aclk);
   endtask
   task automatic t_link_crc();
      wr(A_ST, 32'hFF);
      settle(1'b0, 1'b0);
      rd(A_ST, 32'h3, 32'h0, OK);
      settle(1'b1, 1'b0);
      rd(A_ST, 32'h3, 32'h1, OK);
      wr(A_IST, 32'h3);
      wr(A_MSK, 32'h2);
      check(32'(irq), 32'h0);
      settle(1'b1, 1'b1);
      rd(A_ST, 32'h3, 32'h3, OK);
      check(32'(irq), 32'h1);
      rd(A_IST, 32'h3, 32'h2, OK);
      wr(A_MSK, 32'h0);
      @(posedge aclk);
      check(32'(irq), 32'h0);
      wr(A_IST, 32'h2);
      rd(A_IST, 32'h3, 32'h0, OK);
      wr(A_CTL, 32'h20);
      rd(A_ST, 32'h3, 32'h1, OK);
      wr(A_CTL, 32'h0);
      settle(1'b1, 1'b1);
      settle(1'b0, 1'b0);
      rd(A_ST, 32'h3, 32'h0, OK);
      settle(1'b1, 1'b0);
      wr(12'h100, 32'h1);
      rd(12'h100, 32'hFFFFFFFF, 32'h0, SGLS_RESP_SLVERR);
   endtask
   task automatic t_pins();
      logic [7:0] tbl [6] = '{8'h00, 8'h99, 8'h11, 8'hBB, 8'h55, 8'h44};
      logic [7:0] c;
      logic [2:0] r;
      foreach (tbl[i]) begin
         c = tbl[i];
         wr(A_CFG, {24'h0, c});
         rd(A_CFG, 32'hFFFFFFFF, {24'h0, c}, OK);
         for (r = 3'h0; r < 3'h4; r++) begin
            want_pins <= r[1:0];
            repeat (8) @(posedge aclk);
            check(32'({output_pin_one_oe, output_pin_zero_oe}),
                  32'({c[4], c[0]}));
            if (c[0]) check(32'(output_pin_zero),
                            32'(c[2] ? r[0] : c[3]));
            if (c[4]) check(32'(output_pin_one),
                            32'(c[6] ? r[1] : c[7]));
         end
      end
   endtask
   task automatic final_report();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // hang guard well above the few hundred cycles the tests need
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, crc_req} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      s_axi_wstrb = 4'hF;
      want_pins = 2'h0;
      want_link = 1'b1;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_CFG, 32'hFFFFFFFF, {24'h0, SGLS_PINCFG_RST}, OK);
      t_link_crc();
      t_pins();
      final_report();
   end
endmodule
